/* File: include/uprf_cfg.svh */
// constants for the packet relay framer: characters, codes, sizes
// assumes plain 8-bit ascii characters on both uart streams
`ifndef UPRF_CFG_SVH
`define UPRF_CFG_SVH

// cycle start signature, sent as two characters
`define UPRF_CH_SIG0 8'h50
`define UPRF_CH_SIG1 8'h52
// packet delimiter
`define UPRF_CH_DELIM 8'h3a
// hex character bases
`define UPRF_CH_DIG0 8'h30
`define UPRF_CH_DIG9 8'h39
`define UPRF_CH_UPA 8'h41
`define UPRF_CH_UPF 8'h46
`define UPRF_CH_LOA 8'h61
`define UPRF_CH_LOF 8'h66
`define UPRF_HEX_TEN 4'ha
// service slot address and commands carried in it
`define UPRF_ADDR_SVC 8'h00
`define UPRF_CMD_STOP 8'h01
`define UPRF_CMD_RESTART 8'h02
// buffer toward the network line
`define UPRF_FIFO_DEPTH 32
`define UPRF_ENT_W 10

`endif

/* File: include/uprf_pkg.sv */
// types shared by the packet relay framer files
// assumes uprf_cfg.svh is on the include path
package uprf_pkg;

	// transmit sequencer, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SIG0 = 6'h02,
		ST_SIG1 = 6'h04,
		ST_DELIM = 6'h08,
		ST_HI = 6'h10,
		ST_LO = 6'h20
	} uprf_tx_state_t;

	// kind of a buffered entry toward the network
	typedef enum logic [1:0] {
		ENT_DATA = 2'h0,
		ENT_END = 2'h1,
		ENT_ABORT = 2'h2
	} uprf_ent_t;

endpackage : uprf_pkg

/* File: include/uprf_fifo_if.sv */
// valid/ready carrier between the framer and its buffer
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface uprf_fifo_if #(
	parameter int W = 10
);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;

	modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
	modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface : uprf_fifo_if

`default_nettype wire

/* File: hdl/uprf_fifo.sv */
// buffer of DEPTH words with a registered read stage
// assumes a single clock and an active low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module uprf_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// both sides of the buffer
	uprf_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	// full only counts the array; the read register is one extra place
	assign port.wr_ready = (count != CW'(DEPTH));
	assign push = port.wr_valid && port.wr_ready;
	assign pop = (count != '0) && (!port.rd_valid || port.rd_ready);

	// storage, no reset needed
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wptr] <= port.wr_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// read register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			port.rd_valid <= 1'b0;
			port.rd_data <= '0;
		end else if (pop) begin
			port.rd_valid <= 1'b1;
			port.rd_data <= mem[rptr];
		end else if (port.rd_ready) begin
			port.rd_valid <= 1'b0;
		end
	end

endmodule : uprf_fifo

`default_nettype wire

/* File: hdl/uprf_framer.sv */
// host side uart framer: network packets to hex text and back
// assumes byte-wide uart character streams and a byte-wide network port
// Overview of operation
// - on a network preamble while the carrier is present, send the two-character cycle start signature first.
// - a colon delimiter marks every packet boundary on the uart stream.
// - each packet byte travels as two ascii hex characters, high nibble first.
// - every packet received from the network is forwarded onto the uart.
// - packets from the uart are buffered and relayed unchanged, service packets excepted.
// - packet 0 is the broadcast and service slot for control and status.
// - the host reports its current state inside a service packet.
// - packets cycle only while the network carrier is present.
// - service packets may be sent out of turn, but only between packets or after a signature.
// - both directions use the same signature, delimiter and packet structure.
`timescale 1ns/1ps
`default_nettype none
`include "uprf_cfg.svh"

module uprf_framer import uprf_pkg::*; #(
	parameter int DEPTH = `UPRF_FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// network receive side
	input wire logic net_preamble,
	input wire logic net_carrier,
	input wire logic net_rx_valid,
	input wire logic [7:0] net_rx_data,
	input wire logic net_rx_last,
	output logic net_rx_ready,
	// network transmit side
	output logic net_tx_valid,
	output logic [7:0] net_tx_data,
	output logic net_tx_end,
	output logic net_tx_abort,
	input wire logic net_tx_ready,
	// uart transmit characters
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// uart receive characters
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// service and control
	input wire logic svc_req,
	output logic net_stop,
	output logic net_restart
);

	uprf_fifo_if #(.W(`UPRF_ENT_W)) fifo_port ();

	uprf_fifo #(.W(`UPRF_ENT_W), .DEPTH(DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.port(fifo_port.store)
	);

	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		hex_char = (nib < `UPRF_HEX_TEN) ? `UPRF_CH_DIG0 + 8'(nib) : `UPRF_CH_UPA + 8'(nib - `UPRF_HEX_TEN);
	endfunction : hex_char

	// ---------------- transmit toward controller ----------------
	uprf_tx_state_t tx_state;
	logic sig_pend;
	logic svc_pend;
	logic hold_full;
	logic next_hold_full;
	logic [7:0] hold_byte;
	logic hold_last;
	logic [7:0] cur_byte;
	logic cur_last;
	logic svc_second;
	logic in_pkt;
	logic slot;
	logic emit;
	logic pick_sig;
	logic pick_svc;
	logic use_hold;
	logic take_net;
	logic [7:0] next_char;
	logic [7:0] status;
	logic [3:0] pkt_count;

	// a service packet slips in between packets, or after a signature sent inside one
	assign slot = !tx_valid || tx_ready;
	assign pick_sig = (tx_state == ST_IDLE) && sig_pend;
	assign pick_svc = (tx_state == ST_IDLE) && !sig_pend && svc_pend && !in_pkt;
	assign use_hold = (tx_state == ST_IDLE) && !sig_pend && !pick_svc && hold_full;
	assign take_net = net_rx_valid && net_rx_ready;
	assign next_hold_full = take_net || (hold_full && !use_hold);
	assign emit = slot && (tx_state != ST_IDLE);
	// host state for the service packet
	assign status = {net_carrier, net_stop, !fifo_port.wr_ready, 1'b0, pkt_count};

	// character for the current sequencer state
	always_comb begin
		unique case (tx_state)
			ST_SIG0: next_char = `UPRF_CH_SIG0;
			ST_SIG1: next_char = `UPRF_CH_SIG1;
			ST_DELIM: next_char = `UPRF_CH_DELIM;
			ST_HI: next_char = hex_char(cur_byte[7:4]);
			ST_LO: next_char = hex_char(cur_byte[3:0]);
			default: next_char = `UPRF_CH_DELIM;
		endcase
	end

	// pending requests; a new request wins over the pick that clears it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sig_pend <= 1'b0;
			svc_pend <= 1'b0;
		end else begin
			sig_pend <= (net_preamble && net_carrier) || (sig_pend && !pick_sig);
			svc_pend <= svc_req || (svc_pend && !pick_svc);
		end
	end

	// one byte holding stage from the network
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hold_full <= 1'b0;
			hold_byte <= 8'h00;
			hold_last <= 1'b0;
			net_rx_ready <= 1'b0;
		end else begin
			hold_full <= next_hold_full;
			if (take_net) begin
				hold_byte <= net_rx_data;
				hold_last <= net_rx_last;
			end
			// no carrier or stopped: the network side is not taken
			net_rx_ready <= !next_hold_full && net_carrier && !net_stop;
		end
	end

	// transmit sequencer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_state <= ST_IDLE;
			cur_byte <= 8'h00;
			cur_last <= 1'b0;
			svc_second <= 1'b0;
			in_pkt <= 1'b0;
		end else begin
			unique case (tx_state)
				ST_IDLE: begin
					if (pick_sig) begin
						// a new cycle clears in_pkt; a packet left half sent goes on after the signature
						in_pkt <= 1'b0;
						tx_state <= ST_SIG0;
					end else if (pick_svc) begin
						cur_byte <= `UPRF_ADDR_SVC;
						cur_last <= 1'b0;
						svc_second <= 1'b1;
						tx_state <= ST_HI;
					end else if (use_hold) begin
						cur_byte <= hold_byte;
						cur_last <= hold_last;
						in_pkt <= !hold_last;
						tx_state <= ST_HI;
					end
				end
				ST_SIG0: if (slot) tx_state <= ST_SIG1;
				ST_SIG1: if (slot) tx_state <= ST_DELIM;
				ST_DELIM: if (slot) tx_state <= ST_IDLE;
				ST_HI: if (slot) tx_state <= ST_LO;
				ST_LO: begin
					if (slot) begin
						if (svc_second) begin
							cur_byte <= status;
							cur_last <= 1'b1;
							svc_second <= 1'b0;
							tx_state <= ST_HI;
						end else if (cur_last) begin
							tx_state <= ST_DELIM;
						end else begin
							tx_state <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// uart character output
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else if (emit) begin
			tx_valid <= 1'b1;
			tx_data <= next_char;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	// ---------------- receive from controller ----------------
	logic take_rx;
	logic is_hex;
	logic [3:0] nib;
	logic sig0_seen;
	logic have_hi;
	logic [3:0] hi_nib;
	logic [7:0] byte_idx;
	logic drop;
	logic in_svc;
	logic pend_full;
	logic next_pend_full;
	logic [1:0] pend_kind;
	logic [7:0] pend_data;
	logic push;
	logic [1:0] push_kind;
	logic [7:0] push_data;
	logic [7:0] full_byte;

	assign take_rx = rx_valid && rx_ready;
	assign full_byte = {hi_nib, nib};
	assign next_pend_full = push || (pend_full && !fifo_port.wr_ready);
	assign fifo_port.wr_valid = pend_full;
	assign fifo_port.wr_data = {pend_kind, pend_data};

	// hex character decode
	always_comb begin
		is_hex = 1'b1;
		nib = 4'h0;
		if (rx_data >= `UPRF_CH_DIG0 && rx_data <= `UPRF_CH_DIG9) begin
			nib = 4'(rx_data - `UPRF_CH_DIG0);
		end else if (rx_data >= `UPRF_CH_UPA && rx_data <= `UPRF_CH_UPF) begin
			nib = 4'(rx_data - `UPRF_CH_UPA) + `UPRF_HEX_TEN;
		end else if (rx_data >= `UPRF_CH_LOA && rx_data <= `UPRF_CH_LOF) begin
			nib = 4'(rx_data - `UPRF_CH_LOA) + `UPRF_HEX_TEN;
		end else begin
			is_hex = 1'b0;
		end
	end

	// what one received character places in the buffer
	always_comb begin
		push = 1'b0;
		push_kind = ENT_DATA;
		push_data = 8'h00;
		if (take_rx && !drop && !in_svc) begin
			if (is_hex && have_hi && !(byte_idx == 8'h00 && full_byte == `UPRF_ADDR_SVC)) begin
				push = 1'b1;
				push_data = full_byte;
			end else if (rx_data == `UPRF_CH_DELIM && byte_idx != 8'h00) begin
				push = 1'b1;
				push_kind = have_hi ? ENT_ABORT : ENT_END;
			end else if (!is_hex && rx_data != `UPRF_CH_DELIM && rx_data != `UPRF_CH_SIG0
					&& !(sig0_seen && rx_data == `UPRF_CH_SIG1) && (byte_idx != 8'h00 || have_hi)) begin
				push = 1'b1;
				push_kind = ENT_ABORT;
			end
		end
	end

	// parser counters and flags
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sig0_seen <= 1'b0;
			have_hi <= 1'b0;
			hi_nib <= 4'h0;
			byte_idx <= 8'h00;
			drop <= 1'b0;
			in_svc <= 1'b0;
			pkt_count <= 4'h0;
		end else if (take_rx) begin
			sig0_seen <= (rx_data == `UPRF_CH_SIG0);
			if (sig0_seen && rx_data == `UPRF_CH_SIG1) begin
				// signature restarts the cycle from address 0
				have_hi <= 1'b0;
				byte_idx <= 8'h00;
				drop <= 1'b0;
				in_svc <= 1'b0;
				pkt_count <= 4'h0;
			end else if (rx_data == `UPRF_CH_DELIM) begin
				have_hi <= 1'b0;
				byte_idx <= 8'h00;
				drop <= 1'b0;
				in_svc <= 1'b0;
				if (byte_idx != 8'h00) pkt_count <= pkt_count + 4'h1;
			end else if (is_hex) begin
				if (!have_hi) begin
					hi_nib <= nib;
				end else if (byte_idx != 8'hff) begin
					byte_idx <= byte_idx + 8'h01;
				end
				have_hi <= !have_hi;
				if (have_hi && byte_idx == 8'h00 && full_byte == `UPRF_ADDR_SVC) in_svc <= 1'b1;
			end else if (rx_data != `UPRF_CH_SIG0) begin
				drop <= 1'b1;
			end
		end
	end

	// service commands; restart is a one-cycle pulse
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			net_stop <= 1'b0;
			net_restart <= 1'b0;
		end else begin
			net_restart <= 1'b0;
			if (take_rx && is_hex && have_hi && in_svc && byte_idx == 8'h01 && !drop) begin
				if (full_byte == `UPRF_CMD_STOP) net_stop <= 1'b1;
				if (full_byte == `UPRF_CMD_RESTART) begin
					net_stop <= 1'b0;
					net_restart <= 1'b1;
				end
			end
		end
	end

	// one entry stage in front of the buffer; stalls the uart when full
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pend_full <= 1'b0;
			pend_kind <= ENT_DATA;
			pend_data <= 8'h00;
			rx_ready <= 1'b0;
		end else begin
			pend_full <= next_pend_full;
			if (push) begin
				pend_kind <= push_kind;
				pend_data <= push_data;
			end
			rx_ready <= !next_pend_full;
		end
	end

	// network output stage, held while carrier is absent or stopped
	assign fifo_port.rd_ready = (!net_tx_valid || net_tx_ready) && net_carrier && !net_stop;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			net_tx_valid <= 1'b0;
			net_tx_data <= 8'h00;
			net_tx_end <= 1'b0;
			net_tx_abort <= 1'b0;
		end else if (fifo_port.rd_valid && fifo_port.rd_ready) begin
			net_tx_valid <= 1'b1;
			net_tx_data <= fifo_port.rd_data[7:0];
			net_tx_end <= (fifo_port.rd_data[9:8] == ENT_END);
			net_tx_abort <= (fifo_port.rd_data[9:8] == ENT_ABORT);
		end else if (net_tx_ready) begin
			net_tx_valid <= 1'b0;
		end
	end

endmodule : uprf_framer

`default_nettype wire

/* File: dv/uprf_framer_checker.sv */
// port assertions for the packet relay framer
// assumes one ref_clk domain and resetn active low
`timescale 1ns/1ps
`default_nettype none

module uprf_framer_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// network receive side
	input wire logic net_preamble,
	input wire logic net_carrier,
	input wire logic net_rx_valid,
	input wire logic net_rx_last,
	input wire logic net_rx_ready,
	// network transmit side
	input wire logic net_tx_valid,
	input wire logic [7:0] net_tx_data,
	input wire logic net_tx_end,
	input wire logic net_tx_abort,
	input wire logic net_tx_ready,
	// uart transmit and control
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic net_stop,
	input wire logic net_restart
);
	// all checks share the one clock and reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	chk_sig_first: assert property (net_preamble && net_carrier |-> ##[1:40] (tx_valid && tx_data == 8'h50))
		else $error("signature did not follow preamble");
	chk_sig_pair: assert property (tx_valid && tx_ready && tx_data == 8'h50 |=> ##[0:3] (tx_valid && tx_data == 8'h52))
		else $error("second signature character missing");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("uart character changed before taken");
	chk_tx_chars: assert property (tx_valid |-> tx_data inside {[8'h30:8'h39], [8'h41:8'h46], 8'h50, 8'h52, 8'h3a})
		else $error("uart character outside the protocol set");
	chk_delim_after: assert property (net_rx_valid && net_rx_ready && net_rx_last |-> ##[3:60] (tx_valid && tx_ready && tx_data == 8'h3a))
		else $error("no delimiter after last network byte");
	chk_stop_gate: assert property (net_stop && $past(net_stop) |-> !net_rx_ready)
		else $error("network bytes taken while stopped");
	chk_carrier_gate: assert property (!net_carrier && !$past(net_carrier) |-> !net_rx_ready)
		else $error("network bytes taken without carrier");
	chk_ntx_hold: assert property (net_tx_valid && !net_tx_ready |=> net_tx_valid && $stable(net_tx_data) && $stable(net_tx_end) && $stable(net_tx_abort))
		else $error("network entry changed before taken");
	chk_restart_clr: assert property (net_restart |-> !net_stop ##1 !net_restart)
		else $error("restart pulse malformed");
	chk_ntx_kind: assert property (net_tx_valid |-> !(net_tx_end && net_tx_abort))
		else $error("entry both end and abort");
endmodule : uprf_framer_checker

bind uprf_framer uprf_framer_checker i_chk (.ref_clk(ref_clk), .resetn(resetn), .net_preamble(net_preamble),
	.net_carrier(net_carrier), .net_rx_valid(net_rx_valid), .net_rx_last(net_rx_last), .net_rx_ready(net_rx_ready),
	.net_tx_valid(net_tx_valid), .net_tx_data(net_tx_data), .net_tx_end(net_tx_end), .net_tx_abort(net_tx_abort),
	.net_tx_ready(net_tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.net_stop(net_stop), .net_restart(net_restart));

`default_nettype wire

/* File: dv/uprf_ctrl_model.sv */
// behavioural network controller on the uart side
// assumes the bench fills out_q and reads got
`timescale 1ns/1ps
`default_nettype none

module uprf_ctrl_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// characters from the host
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// characters to the host
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready
);
	logic [7:0] got[$];
	logic [7:0] out_q[$];
	logic slow;
	logic took;
	int unsigned tick;

	initial begin
		slow = 1'b0;
		took = 1'b0;
		tick = 0;
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end

	// capture host characters, same framing both ways
	always @(posedge ref_clk) begin
		if (resetn && tx_valid && tx_ready)
			got.push_back(tx_data);
		took <= rx_valid && rx_ready;
	end

	// slow mode accepts one char in four; idle data flips so nothing stale looks valid
	always @(negedge ref_clk) begin
		tick <= tick + 1;
		tx_ready <= resetn && (!slow || tick[1:0] == 2'h3);
		if (!rx_valid || took) begin
			if (resetn && out_q.size() > 0) begin
				rx_valid <= 1'b1;
				rx_data <= out_q.pop_front();
			end else begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end
		end
	end
endmodule : uprf_ctrl_model

`default_nettype wire

/* File: dv/uprf_framer_tb_top.sv */
// self-checking bench for the packet relay framer
// assumes the controller model on the uart side, bench drives the network side
`timescale 1ns/1ps
`default_nettype none

module uprf_framer_tb_top import uprf_pkg::*; ;
	logic ref_clk, resetn, net_preamble, net_carrier, net_rx_valid, net_rx_last, net_rx_ready;
	logic [7:0] net_rx_data, net_tx_data, tx_data, rx_data;
	logic net_tx_valid, net_tx_end, net_tx_abort, net_tx_ready, tx_valid, tx_ready;
	logic rx_valid, rx_ready, svc_req, net_stop, net_restart;
	logic [9:0] ent_q[$];
	int miscompares, checks;

	// small buffer so the refusal point is reached quickly
	uprf_framer #(.DEPTH(4)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .net_preamble(net_preamble),
		.net_carrier(net_carrier), .net_rx_valid(net_rx_valid), .net_rx_data(net_rx_data), .net_rx_last(net_rx_last),
		.net_rx_ready(net_rx_ready), .net_tx_valid(net_tx_valid), .net_tx_data(net_tx_data), .net_tx_end(net_tx_end),
		.net_tx_abort(net_tx_abort), .net_tx_ready(net_tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .svc_req(svc_req),
		.net_stop(net_stop), .net_restart(net_restart));
	uprf_ctrl_model i_ctrl (.ref_clk(ref_clk), .resetn(resetn), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));

	// 100 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// collect entries toward the network as {abort, end, data}
	always @(posedge ref_clk) begin
		if (resetn && net_tx_valid && net_tx_ready)
			ent_q.push_back({net_tx_abort, net_tx_end, net_tx_data});
	end

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wait_n

	task automatic exp_chars(input string s);
		int n;
		n = 0;
		while (i_ctrl.got.size() < s.len() && n < 400) begin
			wait_n(1);
			n++;
		end
		// a short settle so a character sent once too often is caught as well
		wait_n(8);
		chk(i_ctrl.got.size() == s.len(), "uart character count wrong");
		for (int i = 0; i < s.len() && i < i_ctrl.got.size(); i++)
			chk(i_ctrl.got[i] === s[i], "uart character mismatch");
		i_ctrl.got.delete();
	endtask : exp_chars

	// end and abort carry no data, so only the kind is compared for them
	task automatic exp_ent(input logic [1:0] k, input logic [7:0] d);
		int n;
		n = 0;
		while (ent_q.size() == 0 && n < 400) begin
			wait_n(1);
			n++;
		end
		chk(ent_q.size() > 0 && ent_q[0][9:8] === k && (k != ENT_DATA || ent_q[0][7:0] === d), "entry mismatch");
		if (ent_q.size() > 0)
			void'(ent_q.pop_front());
	endtask : exp_ent

	// valid stays up between bytes so it is never lowered and raised in one step
	task automatic net_send(input logic [7:0] d, input logic last);
		int n;
		n = 0;
		net_rx_valid = 1'b1;
		net_rx_data = d;
		net_rx_last = last;
		while (net_rx_ready !== 1'b1 && n < 200) begin
			wait_n(1);
			n++;
		end
		chk(n < 200, "network byte never taken");
		wait_n(1);
		if (last)
			net_rx_valid = 1'b0;
	endtask : net_send

	task automatic uart_send(input string s);
		for (int i = 0; i < s.len(); i++)
			i_ctrl.out_q.push_back(s[i]);
	endtask : uart_send

	task automatic t_sig();
		net_preamble = 1'b1;
		wait_n(1);
		net_preamble = 1'b0;
		exp_chars("PR:");
	endtask : t_sig

	task automatic t_status();
		svc_req = 1'b1;
		wait_n(1);
		svc_req = 1'b0;
		exp_chars("0080:");
	endtask : t_status

	task automatic t_relay();
		i_ctrl.slow = 1'b1;
		net_send(8'h5a, 1'b0);
		net_send(8'h0c, 1'b1);
		exp_chars("5A0C:");
		i_ctrl.slow = 1'b0;
	endtask : t_relay

	task automatic t_buffer();
		net_tx_ready = 1'b0;
		uart_send("112233445566778899aa:");
		wait_n(100);
		chk(i_ctrl.out_q.size() > 0, "full buffer still took characters");
		net_tx_ready = 1'b1;
		for (int i = 1; i <= 10; i++)
			exp_ent(ENT_DATA, 8'(i * 17));
		exp_ent(ENT_END, 8'h00);
	endtask : t_buffer

	task automatic t_abort();
		// non-hex character, then a packet cut after half a byte
		uart_send("1G:PR3D5:77:");
		exp_ent(ENT_ABORT, 8'h00);
		exp_ent(ENT_DATA, 8'h3d);
		exp_ent(ENT_ABORT, 8'h00);
		exp_ent(ENT_DATA, 8'h77);
		exp_ent(ENT_END, 8'h00);
	endtask : t_abort

	task automatic t_cmd();
		int n;
		n = 0;
		// controller opens its answer with the signature, then the address 0 reply
		uart_send("PR0001:");
		wait_n(30);
		chk(net_stop === 1'b1 && net_rx_ready === 1'b0, "stop not in force");
		uart_send("0002:");
		while (net_restart !== 1'b1 && n < 40) begin
			wait_n(1);
			n++;
		end
		chk(net_restart === 1'b1 && net_stop === 1'b0, "restart missing");
		wait_n(10);
		chk(ent_q.size() == 0, "service packet forwarded");
	endtask : t_cmd

	task automatic t_carrier();
		net_carrier = 1'b0;
		wait_n(3);
		chk(net_rx_ready === 1'b0, "ready without carrier");
		net_preamble = 1'b1;
		wait_n(1);
		net_preamble = 1'b0;
		wait_n(20);
		chk(i_ctrl.got.size() == 0, "signature sent without carrier");
		net_carrier = 1'b1;
	endtask : t_carrier

	// main sequence, inputs change on the falling edge
	initial begin
		miscompares = 0;
		checks = 0;
		resetn = 1'b0;
		net_preamble = 1'b0;
		net_carrier = 1'b1;
		net_rx_valid = 1'b0;
		net_rx_data = 8'h00;
		net_rx_last = 1'b0;
		net_tx_ready = 1'b1;
		svc_req = 1'b0;
		wait_n(5);
		resetn = 1'b1;
		wait_n(2);
		t_sig();
		t_status();
		t_relay();
		t_buffer();
		t_abort();
		t_cmd();
		t_carrier();
		print_verdict();
	end

	// the whole run needs a few hundred cycles
	initial begin
		#100us;
		miscompares++;
		print_verdict();
	end
endmodule : uprf_framer_tb_top

`default_nettype wire
